// [rtl/dqtx_pkg.sv]
// Constants, types and helpers for the DQPSK transmit burst control
// Behaviour
// - Ready rises within 4097 master clocks after wake
// - Ready falls on the edge that starts a burst
// - First bit clock rise three master clocks after burst
// - Ramp down lasts seven and a half bit periods
// - Ready rises within 30 clocks of last fall
// - Data sampled on bit clock fall, one bit/period
// - Envelope ramps up on burst high, down on low
// - Burst output is burst input through pipeline delay
// - Sleep while power low, calibrate on wake
package dqtx_pkg;
   localparam int          CAL_MAX_CYC    = 4097;
   localparam int          SYNC_LAT       = 2;
   localparam int          CAL_CYC        = CAL_MAX_CYC - SYNC_LAT - 1;
   localparam logic [11:0] CAL_LAST       = 12'(CAL_CYC - 1);
   localparam int          START_CYC      = 3;
   localparam int          BCLK_DIV       = 64;
   localparam int          BCLK_HALF      = 32;
   localparam logic [5:0]  DIV_START      = 6'(BCLK_DIV - START_CYC);
   localparam logic [5:0]  DIV_RISE       = 6'(BCLK_DIV - 1);
   localparam logic [5:0]  DIV_FALL       = 6'(BCLK_HALF - 1);
   localparam int          RAMP_HALF_BITS = 15;
   localparam logic [8:0]  RAMP_CYC       = 9'(RAMP_HALF_BITS * BCLK_HALF);
   localparam int          BURST_DELAYED_OUT_DLY_CYC   = 32;
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_STAT      = 12'h004;
   localparam int          CTRL_FSLP_BIT  = 0;
   localparam logic        CTRL_FSLP_RST  = 1'h0;
   localparam int          STAT_READY_BIT = 0;
   localparam int          STAT_BUSY_BIT  = 1;
   localparam int          STAT_SLEEP_BIT = 2;

   typedef enum logic [2:0] {ST_SLEEP, ST_CAL, ST_IDLE, ST_RUN, ST_RAMP} dqtx_state_t;

   // Differential phase step in eighths of a turn for one dibit
   function automatic logic [2:0] phase_step(input logic b1, input logic b2);
      logic [2:0] s;
      unique case ({b1, b2})
         2'h0:    s = 3'h1;
         2'h1:    s = 3'h3;
         2'h3:    s = 3'h5;
         default: s = 3'h7;
      endcase
      return s;
   endfunction : phase_step

   // Cosine of a phase in eighths of a turn, full scale 255
   function automatic logic signed [8:0] cos_lut(input logic [2:0] p);
      logic signed [8:0] c;
      unique case (p)
         3'h0:    c = 9'h0FF;
         3'h1:    c = 9'h0B4;
         3'h3:    c = 9'h14C;
         3'h4:    c = 9'h101;
         3'h5:    c = 9'h14C;
         3'h7:    c = 9'h0B4;
         default: c = 9'h000;
      endcase
      return c;
   endfunction : cos_lut
endpackage : dqtx_pkg

// [rtl/dqtx_dly_if.sv]
// Carrier between the sequencer and the burst delay line
`timescale 1ns/1ps
`default_nettype none
interface dqtx_dly_if;
   logic din;
   logic en;
   logic dout;
   modport src  (output din, output en, input dout);
   modport line (input din, input en, output dout);
endinterface : dqtx_dly_if
`default_nettype wire

// [rtl/dqtx_sync.sv]
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module dqtx_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : dqtx_sync
`default_nettype wire

// [rtl/dqtx_delay.sv]
// Burst delay line matching the transmit path latency
`timescale 1ns/1ps
`default_nettype none
module dqtx_delay (
   input  wire logic clk,
   input  wire logic rst_b,
   dqtx_dly_if.line  dl
);
   localparam int N = dqtx_pkg::BURST_DELAYED_OUT_DLY_CYC;

   logic [N-1:0] sr;
   logic [5:0]   en_run;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         sr <= '0;
      else if (dl.en)
         sr <= {sr[N-2:0], dl.din};
   end

   assign dl.dout = sr[N-1];

   // Counts uninterrupted enabled cycles so the check starts on a full line
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         en_run <= 6'h00;
      else if (!dl.en)
         en_run <= 6'h00;
      else if (en_run != 6'(N))
         en_run <= en_run + 6'h01;
   end

   property p_burst_delayed_out;
      @(posedge clk) disable iff (!rst_b)
      (en_run == 6'(N)) |-> (dl.dout == $past(dl.din, N));
   endproperty
   a_burst_delayed_out: assert property (p_burst_delayed_out) else $error("burst delay mismatch");
endmodule : dqtx_delay
`default_nettype wire

// [rtl/dqtx_top.sv]
// Burst sequencing, bit clock, symbol intake and register slave
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dqtx_top (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        mclk,
   input  wire logic        power_in,
   input  wire logic        burst_enable_in,
   input  wire logic        serial_tx_bits,
   output var  logic        bit_clock_out,
   output var  logic        ready_out,
   output wire logic        burst_delayed_out,
   output var  logic [9:0]  i_channel_out,
   output var  logic [9:0]  q_channel_out
);
   localparam int CAL_BOUND = 4095;
   localparam int RAMP_LO   = 479;
   localparam int RAMP_HI   = 481;
   localparam int DONE_MAX  = 30;

   dqtx_pkg::dqtx_state_t state;
   dqtx_pkg::dqtx_state_t next_state;

   logic [3:0]  pin_s;
   logic        fs_m;
   logic [2:0]  stat_m;
   logic [2:0]  stat_c;
   logic        force_sleep;
   logic [11:0] cal_cnt;
   logic [5:0]  div;
   logic [8:0]  env;
   logic        half;
   logic        first_bit;
   logic [2:0]  phase;
   logic [12:0] cal_age;
   logic [5:0]  hi_len;

   dqtx_dly_if dly ();

   // Pins and the clock enable cross into the master clock domain
   dqtx_sync #(.WIDTH(4)) u_pin_sync (
      .clk   (mclk),
      .rst_b (rst_b),
      .d     ({ce, power_in, burst_enable_in, serial_tx_bits}),
      .q     (pin_s)
   );

   dqtx_sync #(.WIDTH(1)) u_fs_sync (
      .clk   (mclk),
      .rst_b (rst_b),
      .d     (force_sleep),
      .q     (fs_m)
   );

   // Status flags are independent levels, so per-bit crossing is safe
   dqtx_sync #(.WIDTH(3)) u_stat_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (stat_m),
      .q     (stat_c)
   );

   dqtx_delay u_delay (
      .clk   (mclk),
      .rst_b (rst_b),
      .dl    (dly.line)
   );

   wire ce_m   = pin_s[3];
   wire pw_s   = pin_s[2];
   wire bin_s  = pin_s[1];
   wire dat_s  = pin_s[0];
   wire asleep = ~pw_s | fs_m;
   wire run    = (state == dqtx_pkg::ST_RUN) | (state == dqtx_pkg::ST_RAMP);
   wire fall   = bit_clock_out & (div == dqtx_pkg::DIV_FALL);
   wire rise   = ~bit_clock_out & (div == dqtx_pkg::DIV_RISE);
   wire sym_in = fall & half & (state == dqtx_pkg::ST_RUN);
   wire bin_go = (state == dqtx_pkg::ST_IDLE) & bin_s & ~asleep;
   wire [2:0] step = dqtx_pkg::phase_step(first_bit, dat_s);

   wire signed [18:0] i_prod = dqtx_pkg::cos_lut(phase) * $signed({1'b0, env});
   wire signed [18:0] q_prod = dqtx_pkg::cos_lut(phase - 3'h2) * $signed({1'b0, env});

   assign dly.din           = bin_s;
   assign dly.en            = ce_m;
   assign burst_delayed_out = dly.dout;

   always_comb
   begin
      next_state = state;
      unique case (state)
         dqtx_pkg::ST_SLEEP:
            next_state = dqtx_pkg::ST_CAL;
         dqtx_pkg::ST_CAL:
            if (cal_cnt == dqtx_pkg::CAL_LAST)
               next_state = dqtx_pkg::ST_IDLE;
         dqtx_pkg::ST_IDLE:
            if (bin_s)
               next_state = dqtx_pkg::ST_RUN;
         dqtx_pkg::ST_RUN:
            // The burst ends only on a whole symbol
            if (sym_in && !bin_s)
               next_state = dqtx_pkg::ST_RAMP;
         dqtx_pkg::ST_RAMP:
            if (fall && env == 9'h000)
               next_state = dqtx_pkg::ST_IDLE;
         default:
            next_state = dqtx_pkg::ST_SLEEP;
      endcase
      if (asleep)
         next_state = dqtx_pkg::ST_SLEEP;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         state <= dqtx_pkg::ST_SLEEP;
      else if (ce_m)
         state <= next_state;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cal_cnt <= 12'h000;
      else if (ce_m)
         cal_cnt <= (state == dqtx_pkg::ST_CAL) ? cal_cnt + 12'h001 : 12'h000;
   end

   // Ready is high only while idle and calibrated
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         ready_out <= 1'b0;
      else if (ce_m)
         ready_out <= (next_state == dqtx_pkg::ST_IDLE);
   end

   // Preloading the divider puts the first rise three clocks out
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         div <= 6'h00;
      else if (ce_m)
         div <= bin_go ? dqtx_pkg::DIV_START : (run ? div + 6'h01 : 6'h00);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         bit_clock_out <= 1'b0;
      else if (ce_m)
         bit_clock_out <= run & ~asleep & (rise | (bit_clock_out & ~fall));
   end

   // Bits pair into dibits, first bit is the high one
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         half      <= 1'b0;
         first_bit <= 1'b0;
         phase     <= 3'h0;
      end
      else if (ce_m)
      begin
         if (bin_go)
            half <= 1'b0;
         else if (fall && state == dqtx_pkg::ST_RUN)
         begin
            half      <= ~half;
            first_bit <= half ? first_bit : dat_s;
            phase     <= half ? phase + step : phase;
         end
      end
   end

   // Envelope climbs during the burst and falls after it
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         env <= 9'h000;
      else if (ce_m)
      begin
         if (state == dqtx_pkg::ST_RUN && env != dqtx_pkg::RAMP_CYC)
            env <= env + 9'h001;
         else if (state != dqtx_pkg::ST_RUN && env != 9'h000)
            env <= env - 9'h001;
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         i_channel_out <= 10'h000;
         q_channel_out <= 10'h000;
      end
      else if (ce_m)
      begin
         i_channel_out <= i_prod[17:8];
         q_channel_out <= q_prod[17:8];
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         stat_m <= 3'h0;
      else if (ce_m)
      begin
         stat_m[dqtx_pkg::STAT_READY_BIT] <= ready_out;
         stat_m[dqtx_pkg::STAT_BUSY_BIT]  <= run;
         stat_m[dqtx_pkg::STAT_SLEEP_BIT] <= (state == dqtx_pkg::ST_SLEEP);
      end
   end

   // Register slave, one wait state on every transfer
   wire        acc      = psel & penable;
   wire        hit_ctrl = (paddr == dqtx_pkg::ADDR_CTRL);
   wire        hit_stat = (paddr == dqtx_pkg::ADDR_STAT);
   wire        mapped   = hit_ctrl | hit_stat;
   wire [31:0] ctrl_rd  = 32'(force_sleep) << dqtx_pkg::CTRL_FSLP_BIT;
   wire [31:0] rd_mux   = hit_ctrl ? ctrl_rd : (hit_stat ? {29'h0, stat_c} : 32'h0);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else if (ce)
      begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~mapped;
         prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         force_sleep <= dqtx_pkg::CTRL_FSLP_RST;
      else if (ce && acc && pready && pwrite && hit_ctrl)
         force_sleep <= pwdata[dqtx_pkg::CTRL_FSLP_BIT];
   end

   // Checker helpers
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cal_age <= 13'h0000;
         hi_len  <= 6'h00;
      end
      else
      begin
         cal_age <= (state == dqtx_pkg::ST_CAL) ? cal_age + 13'h0001 : 13'h0000;
         hi_len  <= bit_clock_out ? hi_len + 6'h01 : 6'h00;
      end
   end

   property p_cal;
      @(posedge mclk) disable iff (!rst_b)
      (state == dqtx_pkg::ST_CAL) |-> (cal_age < 13'(CAL_BOUND));
   endproperty
   a_cal: assert property (p_cal) else $error("calibration overran");

   property p_rdy_low;
      @(posedge mclk) disable iff (!rst_b)
      (bin_go && ce_m) |=> !ready_out;
   endproperty
   a_rdy_low: assert property (p_rdy_low) else $error("ready not dropped");

   property p_first_rise;
      @(posedge mclk) disable iff (!rst_b)
      (bin_go && ce_m && pw_s) |-> ##4 $rose(bit_clock_out);
   endproperty
   a_first_rise: assert property (p_first_rise) else $error("first bit clock late");

   property p_bclk_high;
      @(posedge mclk) disable iff (!rst_b)
      ($fell(bit_clock_out) && state != dqtx_pkg::ST_SLEEP) |-> (hi_len == 6'h20);
   endproperty
   a_bclk_high: assert property (p_bclk_high) else $error("bit clock high time");

   property p_symbol;
      @(posedge mclk) disable iff (!rst_b)
      (sym_in && ce_m && !asleep)
         |=> (phase == $past(phase) + dqtx_pkg::phase_step($past(first_bit), $past(dat_s)));
   endproperty
   a_symbol: assert property (p_symbol) else $error("dibit not taken");

   property p_ramp_dn;
      @(posedge mclk) disable iff (!rst_b)
      ($rose(state == dqtx_pkg::ST_RAMP) && env == dqtx_pkg::RAMP_CYC)
         |-> ##[RAMP_LO:RAMP_HI] (env == 9'h000);
   endproperty
   a_ramp_dn: assert property (p_ramp_dn) else $error("ramp down length");

   property p_done;
      @(posedge mclk) disable iff (!rst_b)
      (state == dqtx_pkg::ST_RAMP && fall && env == 9'h000 && !asleep && ce_m)
         |-> ##[1:DONE_MAX] ready_out;
   endproperty
   a_done: assert property (p_done) else $error("ready late after burst");

   property p_ramp_up;
      @(posedge mclk) disable iff (!rst_b)
      (state == dqtx_pkg::ST_RUN && env < dqtx_pkg::RAMP_CYC && ce_m && !asleep)
         |=> (env == $past(env) + 9'h001);
   endproperty
   a_ramp_up: assert property (p_ramp_up) else $error("envelope not rising");

   property p_sleep;
      @(posedge mclk) disable iff (!rst_b)
      (asleep && ce_m) |=> (state == dqtx_pkg::ST_SLEEP) && !ready_out && !bit_clock_out;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not entered");
endmodule : dqtx_top
`default_nettype wire

// [testbench/dqtx_host_model.sv]
// Baseband host model: burst control and serial symbol bits
`timescale 1ns/1ps
`default_nettype none
module dqtx_host_model #(
   parameter int         NB   = 8,
   parameter logic [7:0] PAT  = 8'hB4,
   parameter int         DROP = 28
) (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic go,
   input  wire logic bit_clock_out,
   input  wire logic ready_out,
   output var  logic burst_enable_in,
   output var  logic serial_tx_bits
);
   logic [7:0] sh;
   logic [5:0] hi;
   int         idx;
   logic       prev;
   wire  logic fell = prev & ~bit_clock_out;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         burst_enable_in <= 1'h0;
         serial_tx_bits  <= 1'h0;
         sh              <= 8'h00;
         hi              <= 6'h00;
         idx             <= 0;
         prev            <= 1'h0;
      end
      else
      begin
         prev <= bit_clock_out;
         hi   <= bit_clock_out ? hi + 6'h01 : 6'h00;
         if (!burst_enable_in)
         begin
            // Released line toggles so a stale bit is never mistaken for data
            serial_tx_bits <= ~serial_tx_bits;
            if (go && ready_out)
            begin
               burst_enable_in <= 1'h1;
               serial_tx_bits  <= PAT[NB-1];
               sh              <= PAT << 1;
               idx             <= 0;
            end
         end
         else if (fell)
         begin
            serial_tx_bits <= sh[NB-1];
            sh             <= sh << 1;
            idx            <= idx + 1;
         end
         else if (idx == NB - 1 && hi == 6'(DROP))
            burst_enable_in <= 1'h0;
      end
   end
endmodule : dqtx_host_model
`default_nettype wire

// [testbench/dqtx_top_tb.sv]
// Self-checking bench for the transmit burst control
`timescale 1ns/1ps
`default_nettype none
module dqtx_top_tb;
   localparam int NB = 8;
   logic        clk = 1'h0, mclk = 1'h0, rst_b = 1'h0, go = 1'h0;
   logic        ce = 1'h1;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, power_in = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, burst_enable_in, serial_tx_bits;
   logic        bit_clock_out, ready_out, burst_delayed_out;
   logic [9:0]  i_channel_out, q_channel_out;
   int          error_cnt = 0, n_compared = 0;
   int          n, na, h, l, falls, since, dn;
   logic        pv;

   always #5 clk = ~clk;
   initial
   begin
      #1.3;
      forever #3 mclk = ~mclk;
   end

   dqtx_top DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mclk(mclk), .power_in(power_in), .burst_enable_in(burst_enable_in),
      .serial_tx_bits(serial_tx_bits), .bit_clock_out(bit_clock_out), .ready_out(ready_out),
      .burst_delayed_out(burst_delayed_out), .i_channel_out(i_channel_out),
      .q_channel_out(q_channel_out));

   dqtx_host_model #(.NB(NB)) host (.mclk(mclk), .rst_b(rst_b), .go(go),
      .bit_clock_out(bit_clock_out), .ready_out(ready_out),
      .burst_enable_in(burst_enable_in), .serial_tx_bits(serial_tx_bits));

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Holds the request until pready is sampled high, then releases it
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel   <= 1'h1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      // No wait count is assumed; only the watchdog ends a stuck transfer
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
      logic [31:0] r;
      logic        e;
      apb(1'h0, a, 32'h0, r, e);
      check("prdata", r, exp);
      check("pslverr", 32'(e), 32'(eexp));
   endtask : reg_chk

   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'h1, a, d, r, e);
   endtask : reg_wr

   // Counts master clocks until ready, bounded well past the calibration time
   task automatic wait_ready(output int c);
      c = 0;
      // Ready is looked at half a period after the edge that launches it
      do
      begin
         @(posedge mclk);
         c++;
         @(negedge mclk);
      end
      while (ready_out !== 1'h1 && c < 5000);
   endtask : wait_ready

   initial
   begin
      #300us;
      error_cnt++;
      give_verdict();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'h1;
      repeat (10) @(posedge clk);
      reg_chk(12'h000, 32'h0, 1'h0);
      reg_chk(12'h004, 32'h4, 1'h0);
      reg_chk(12'h008, 32'h0, 1'h1);
      check("ready_sleep", 32'(ready_out), 32'h0);
      $display("test reset done");

      @(posedge clk);
      power_in <= 1'h1;
      wait_ready(n);
      check("cal_time", 32'(n <= 4097), 32'h1);
      // Status bits need two APB clocks to cross over
      repeat (4) @(posedge clk);
      reg_chk(12'h004, 32'h1, 1'h0);
      $display("test wake done");

      @(posedge clk);
      go <= 1'h1;
      n = 0;
      na = -1;
      while (bit_clock_out !== 1'h1 && n < 100)
      begin
         @(posedge mclk);
         n++;
         if (ready_out !== 1'h1 && na < 0)
            na = n;
      end
      go <= 1'h0;
      check("ready_to_bclk", 32'(n - na), 32'h3);
      check("burst_delayed_out_early", 32'(burst_delayed_out), 32'h0);
      h = 0;
      l = 0;
      while (bit_clock_out === 1'h1 && h < 100)
      begin
         @(posedge mclk);
         h++;
      end
      while (bit_clock_out === 1'h0 && l < 100)
      begin
         @(posedge mclk);
         l++;
      end
      check("bclk_high", 32'(h), 32'h20);
      check("bclk_low", 32'(l), 32'h20);
      check("burst_delayed_out_on", 32'(burst_delayed_out), 32'h1);
      check("iq_live", 32'(i_channel_out !== 10'h0 || q_channel_out !== 10'h0), 32'h1);
      reg_chk(12'h004, 32'h2, 1'h0);
      falls = 0;
      since = 0;
      dn = 0;
      n = 0;
      pv = bit_clock_out;
      while (ready_out !== 1'h1 && n < 3000)
      begin
         @(posedge mclk);
         n++;
         since++;
         if (pv === 1'h1 && bit_clock_out === 1'h0)
         begin
            falls++;
            since = 0;
         end
         pv = bit_clock_out;
         if (burst_enable_in === 1'h0)
            dn++;
      end
      check("falls", 32'(falls), 32'(NB + 7));
      check("fall_to_ready", 32'(since <= 30), 32'h1);
      check("ramp_len", 32'(dn >= 480 && dn <= 560), 32'h1);
      check("i_end", 32'(i_channel_out), 32'h0);
      check("q_end", 32'(q_channel_out), 32'h0);
      check("bclk_end", 32'(bit_clock_out), 32'h0);
      repeat (40) @(posedge mclk);
      check("burst_delayed_out_off", 32'(burst_delayed_out), 32'h0);
      $display("test burst done");

      reg_wr(12'h000, 32'h1);
      repeat (6) @(posedge mclk);
      check("ready_forced", 32'(ready_out), 32'h0);
      reg_chk(12'h000, 32'h1, 1'h0);
      reg_chk(12'h004, 32'h4, 1'h0);
      reg_wr(12'h000, 32'h0);
      wait_ready(n);
      check("recal_time", 32'(n <= 4100), 32'h1);
      // Clock enable low must hold off the sleep request
      @(posedge clk);
      ce       <= 1'h0;
      power_in <= 1'h0;
      repeat (10) @(posedge mclk);
      check("ready_frozen", 32'(ready_out), 32'h1);
      @(posedge clk);
      ce <= 1'h1;
      repeat (6) @(posedge mclk);
      check("ready_off", 32'(ready_out), 32'h0);
      reg_chk(12'h004, 32'h4, 1'h0);
      $display("test sleep done");
      give_verdict();
   end
endmodule : dqtx_top_tb
`default_nettype wire
